// ===== hw/gpio_port_defines.vh
/*
 * Constants for the packet-driven gpio/pwm port: command codes,
 * payload fields, drive codes, timing figures.
 * Assumes inclusion by bare name from the port module.
 */
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

`define CMD_SET_PIN 8'h22
`define CMD_READ_PIN 8'h23
`define CMD_STORE_BOOT 8'h04
`define REPLY_OR_MASK 8'h40
`define REPLY_ERROR 8'hC0
`define NUM_IO_PINS 5
`define NUM_LED_CH 8
`define LAST_INDEX 8'h0C
`define LAST_IO_INDEX 8'h04
`define VAL_LOW 8'h00
`define VAL_HIGH 8'h64
`define VAL_MAX_ACCEPT 8'hFF
`define CFG_FUNC_BIT 3
`define CFG_RSVD_MASK 8'hF0
`define CFG_DRIVE_MASK 8'h07
`define DRV_RESERVED 3'h6
`define DRV_UP_PULLDN 3'h0
`define DRV_STRONG_A 3'h1
`define DRV_HIZ 3'h2
`define DRV_PULLUP_DN 3'h3
`define DRV_UP_FLOAT 3'h4
`define DRV_STRONG_B 3'h5
`define DRV_FLOAT_DN 3'h7
`define CFG_RESET 4'h2
`define CLK_HZ 125000000
`define PWM_HZ 100
`define SAMPLE_HZ 32
`define PWM_STEPS 100
`define LEN_READ 8'h01
`define LEN_VALUE_ONLY 8'h02
`define LEN_WITH_CFG 8'h03
`define LEN_READ_REPLY 8'h04
`define PIN_PWR_SENSE 1
`define PIN_PWR_CTL 2
`define PIN_RST_CTL 3

`endif

// ===== hw/packet_gpio_pwm_port.v
/*
 * Packet-driven gpio/pwm port: five two-way pins with drive codes,
 * function select and pwm, eight led channels, 32 Hz sampling with
 * sticky edge flags, reply builder, boot-state snapshot.
 * Assumes a packet layer outside that parses frames into a one-cycle
 * command strobe with type, length and three payload bytes, and that
 * frames the reply bytes it is handed. Pin pads are resolved outside.
 */
`timescale 1ns/1ps
`include "gpio_port_defines.vh"

module packet_gpio_pwm_port #(
	parameter NPIN = `NUM_IO_PINS,
	parameter NLED = `NUM_LED_CH,
	parameter CLK_HZ = `CLK_HZ,
	parameter PWM_TICK_CYC = `CLK_HZ / (`PWM_HZ * `PWM_STEPS),
	parameter SAMPLE_CYC = `CLK_HZ / `SAMPLE_HZ
) (
	// clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// parsed command from the packet layer
	input wire cmd_valid_in,
	input wire [7:0] cmd_type_in,
	input wire [7:0] cmd_len_in,
	input wire [7:0] cmd_d0_in,
	input wire [7:0] cmd_d1_in,
	input wire [7:0] cmd_d2_in,
	// reply to the packet layer
	output reg reply_valid_out,
	output reg [7:0] reply_type_out,
	output reg [7:0] reply_len_out,
	output reg [7:0] reply_d0_out,
	output reg [7:0] reply_d1_out,
	output reg [7:0] reply_d2_out,
	output reg [7:0] reply_d3_out,
	// two-way pins on the user pin header, oe low drives
	input wire [NPIN-1:0] pin_in,
	output reg [NPIN-1:0] pin_out,
	output reg [NPIN-1:0] pin_oe_n_out,
	output reg [NPIN-1:0] pin_pullup_out,
	output reg [NPIN-1:0] pin_pulldown_out,
	// led output channels
	output reg [NLED-1:0] led_output_channel_out,
	// default roles of pins 1..3 when function bit is clear; user_ctl_out mirrors each pin's function bit
	output reg host_power_sense_out,
	input wire host_power_ctl_in,
	input wire host_reset_ctl_in,
	output reg [NPIN-1:0] user_ctl_out
);

	localparam NCH = NPIN + NLED;

	// state per channel
	reg [7:0] value_q [0:NCH-1];
	reg [3:0] cfg_q [0:NPIN-1];
	reg [3:0] boot_cfg_q [0:NPIN-1];
	reg [NPIN-1:0] level_q;
	reg [NPIN-1:0] rise_q;
	reg [NPIN-1:0] fall_q;
	reg boot_load_q;
	// low until the first sample, so the reset level gives no false edge
	reg smp_primed_q;

	// timing dividers
	reg [31:0] pwm_div_q;
	reg [6:0] pwm_step_q;
	reg [31:0] smp_div_q;
	wire pwm_tick = (pwm_div_q == PWM_TICK_CYC - 1);
	wire smp_tick = (smp_div_q == SAMPLE_CYC - 1);
	wire smp_edge_ok = smp_tick && smp_primed_q;

	// requested level now, from value and pwm phase
	function lvl_of;
		input [7:0] v;
		input [6:0] step;
		begin
			lvl_of = (v >= `VAL_HIGH) ? 1'b1 : ({1'b0, step} < v);
		end
	endfunction

	function valid_value;
		input [7:0] v;
		begin
			valid_value = (v <= `VAL_HIGH) || (v == `VAL_MAX_ACCEPT);
		end
	endfunction

	// refused config: reserved drive code or upper bits set
	function cfg_refused;
		input [7:0] c;
		begin
			cfg_refused = (c[2:0] == `DRV_RESERVED) ||
				((c & `CFG_RSVD_MASK) != 8'h00);
		end
	endfunction

	// addressed-channel match, shared by every per-channel write
	function hit;
		input [3:0] idx;
		input integer ch;
		begin
			hit = ({28'h0, idx} == ch);
		end
	endfunction

	// command decode
	wire is_set = cmd_valid_in && (cmd_type_in == `CMD_SET_PIN);
	wire is_read = cmd_valid_in && (cmd_type_in == `CMD_READ_PIN);
	// store-boot gives no reply from this block
	wire is_store = cmd_valid_in && (cmd_type_in == `CMD_STORE_BOOT);
	wire idx_ok = (cmd_d0_in <= `LAST_INDEX);
	wire idx_io = (cmd_d0_in <= `LAST_IO_INDEX);
	wire has_cfg = (cmd_len_in == `LEN_WITH_CFG);
	wire cfg_bad = has_cfg && idx_io && cfg_refused(cmd_d2_in);
	wire len_ok = (cmd_len_in == `LEN_VALUE_ONLY) || has_cfg;
	wire set_ok = idx_ok && len_ok && valid_value(cmd_d1_in) && !cfg_bad;
	wire read_ok = idx_ok && (cmd_len_in == `LEN_READ);
	wire set_hit = is_set && set_ok;
	wire rd_hit = is_read && read_ok;
	wire [3:0] idx4 = cmd_d0_in[3:0];
	wire [2:0] idx3 = cmd_d0_in[2:0];
	// 255 is left as a keep-value code; stored value stays 0..100
	wire [7:0] new_val = (cmd_d1_in == `VAL_MAX_ACCEPT) ?
		value_q[idx4] : cmd_d1_in;

	// pwm divider: one tick per duty step
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			pwm_div_q <= 32'h0;
		else
			pwm_div_q <= pwm_tick ? 32'h0 : pwm_div_q + 32'h1;
	end

	// duty step wraps once per pwm period
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			pwm_step_q <= 7'h0;
		else if (pwm_tick)
			pwm_step_q <= (pwm_step_q == `PWM_STEPS - 1) ?
				7'h0 : pwm_step_q + 7'h1;
	end

	// sample divider free-runs, so host reads never shift the grid
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			smp_div_q <= 32'h0;
			smp_primed_q <= 1'b0;
		end else begin
			smp_div_q <= smp_tick ? 32'h0 : smp_div_q + 32'h1;
			if (smp_tick)
				smp_primed_q <= 1'b1;
		end
	end

	// channel values and configs
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_val
			always @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in)
					value_q[g] <= `VAL_LOW;
				else if (set_hit && hit(idx4, g))
					value_q[g] <= new_val;
			end
		end

		for (g = 0; g < NPIN; g = g + 1) begin : g_pin
			// asked-for level; control pins follow the host lines
			// while in their default role
			wire def_role = !cfg_q[g][`CFG_FUNC_BIT];
			wire lv_w;
			assign lv_w = (def_role && g == `PIN_PWR_CTL) ?
				host_power_ctl_in :
				(def_role && g == `PIN_RST_CTL) ?
				host_reset_ctl_in :
				lvl_of(value_q[g], pwm_step_q);
			always @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cfg_q[g] <= `CFG_RESET;
					boot_cfg_q[g] <= `CFG_RESET;
				end else begin
					// power-up load of boot_cfg_q, which reset also sets to CFG_RESET
					if (boot_load_q)
						cfg_q[g] <= boot_cfg_q[g];
					else if (set_hit && has_cfg && hit(idx4, g))
						cfg_q[g] <= cmd_d2_in[3:0];
					if (is_store)
						boot_cfg_q[g] <= cfg_q[g];
				end
			end
			// sampling and sticky edges; a new edge wins over a read clear
			always @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					level_q[g] <= 1'b0;
					rise_q[g] <= 1'b0;
					fall_q[g] <= 1'b0;
				end else begin
					if (smp_tick)
						level_q[g] <= pin_in[g];
					if (smp_edge_ok && pin_in[g] && !level_q[g])
						rise_q[g] <= 1'b1;
					else if (rd_hit && hit(idx4, g))
						rise_q[g] <= 1'b0;
					if (smp_edge_ok && !pin_in[g] && level_q[g])
						fall_q[g] <= 1'b1;
					else if (rd_hit && hit(idx4, g))
						fall_q[g] <= 1'b0;
				end
			end
			// drive code to pad controls
			always @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					pin_out[g] <= 1'b0;
					pin_oe_n_out[g] <= 1'b1;
					pin_pullup_out[g] <= 1'b0;
					pin_pulldown_out[g] <= 1'b0;
					user_ctl_out[g] <= 1'b0;
				end else begin
					user_ctl_out[g] <= cfg_q[g][`CFG_FUNC_BIT];
					pin_out[g] <= lv_w;
					pin_pullup_out[g] <= 1'b0;
					pin_pulldown_out[g] <= 1'b0;
					case (cfg_q[g][2:0])
					`DRV_UP_PULLDN: begin
						pin_oe_n_out[g] <= !lv_w;
						pin_pulldown_out[g] <= !lv_w;
					end
					`DRV_STRONG_A, `DRV_STRONG_B: pin_oe_n_out[g] <= 1'b0;
					`DRV_HIZ: pin_oe_n_out[g] <= 1'b1;
					`DRV_PULLUP_DN: begin
						pin_oe_n_out[g] <= lv_w;
						pin_pullup_out[g] <= lv_w;
					end
					`DRV_UP_FLOAT: pin_oe_n_out[g] <= !lv_w;
					`DRV_FLOAT_DN: pin_oe_n_out[g] <= lv_w;
					default: pin_oe_n_out[g] <= 1'b1;
					endcase
				end
			end
		end

		// leds have no drive code: plain level or pwm
		for (g = 0; g < NLED; g = g + 1) begin : g_led
			always @(posedge core_clk_in or negedge rst_n_in) begin
				if (!rst_n_in)
					led_output_channel_out[g] <= 1'b0;
				else
					led_output_channel_out[g] <=
						lvl_of(value_q[NPIN+g], pwm_step_q);
			end
		end
	endgenerate

	// one-cycle pulse after reset release reloads boot_cfg_q, which reset sets to CFG_RESET
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			boot_load_q <= 1'b1;
		else
			boot_load_q <= 1'b0;
	end

	// power sense follows the sampled pin 1 while in default role
	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			host_power_sense_out <= 1'b0;
		else
			host_power_sense_out <= !cfg_q[`PIN_PWR_SENSE][`CFG_FUNC_BIT] &
				level_q[`PIN_PWR_SENSE];
	end

	// reply builder: next reply worked out here, registered below
	reg reply_valid_d;
	reg [7:0] reply_type_d;
	reg [7:0] reply_len_d;
	reg [7:0] reply_d0_d;
	reg [7:0] reply_d1_d;
	reg [7:0] reply_d2_d;
	reg [7:0] reply_d3_d;

	always @* begin
		reply_valid_d = is_set || is_read;
		reply_type_d = reply_type_out;
		reply_len_d = 8'h00;
		reply_d0_d = 8'h00;
		reply_d1_d = 8'h00;
		reply_d2_d = 8'h00;
		reply_d3_d = 8'h00;
		if (is_set) begin
			if (set_ok)
				reply_type_d = cmd_type_in | `REPLY_OR_MASK;
			else
				reply_type_d = `REPLY_ERROR;
		end else if (is_read && !read_ok) begin
			reply_type_d = `REPLY_ERROR;
		end else if (is_read) begin
			reply_type_d = cmd_type_in | `REPLY_OR_MASK;
			reply_len_d = `LEN_READ_REPLY;
			reply_d0_d = cmd_d0_in;
			reply_d2_d = value_q[idx4];
			if (idx_io) begin
				reply_d1_d = {5'h00, rise_q[idx3], fall_q[idx3],
					level_q[idx3]};
				reply_d3_d = {4'h0, cfg_q[idx3]};
			end
		end
	end

	always @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reply_valid_out <= 1'b0;
			reply_type_out <= 8'h00;
			reply_len_out <= 8'h00;
			reply_d0_out <= 8'h00;
			reply_d1_out <= 8'h00;
			reply_d2_out <= 8'h00;
			reply_d3_out <= 8'h00;
		end else begin
			reply_valid_out <= reply_valid_d;
			reply_type_out <= reply_type_d;
			reply_len_out <= reply_len_d;
			reply_d0_out <= reply_d0_d;
			reply_d1_out <= reply_d1_d;
			reply_d2_out <= reply_d2_d;
			reply_d3_out <= reply_d3_d;
		end
	end

endmodule

// ===== tb/packet_gpio_pwm_port_sva.sv
/* command/reply checks for the gpio port.
   assumes one-cycle cmd strobe and replies one cycle later. */
`timescale 1ns/1ps
module gpio_port_chk (
	// clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// command
	input wire cmd_valid_in,
	input wire [7:0] cmd_type_in,
	input wire [7:0] cmd_len_in,
	input wire [7:0] cmd_d0_in,
	input wire [7:0] cmd_d1_in,
	input wire [7:0] cmd_d2_in,
	// reply
	input wire reply_valid_out,
	input wire [7:0] reply_type_out,
	input wire [7:0] reply_len_out,
	input wire [7:0] reply_d0_out,
	input wire [7:0] reply_d1_out,
	input wire [7:0] reply_d3_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire is_set = cmd_valid_in && cmd_type_in == 8'h22;
	wire is_rd = cmd_valid_in && cmd_type_in == 8'h23;
	sequence set_ok;
		is_set && cmd_len_in == 8'h02 && cmd_d0_in <= 8'h0C
			&& cmd_d1_in <= 8'h64;
	endsequence
	sequence read_ok;
		is_rd && cmd_len_in == 8'h01 && cmd_d0_in <= 8'h0C;
	endsequence
	a_reply_one_cycle: assert property (
		(is_set || is_rd) |=> reply_valid_out)
		else $error("reply missing");
	a_no_spur_reply: assert property (
		!cmd_valid_in |=> !reply_valid_out)
		else $error("reply without command");
	a_set_ack_type: assert property (
		set_ok |=> reply_type_out == 8'h62 && reply_len_out == 8'h00)
		else $error("bad set reply");
	a_read_ack_fmt: assert property (
		read_ok |=> reply_type_out == 8'h63 && reply_len_out == 8'h04
		&& reply_d0_out == $past(cmd_d0_in))
		else $error("bad read reply");
	a_bad_index_err: assert property (
		(is_set || is_rd) && cmd_d0_in > 8'h0C
		|=> reply_type_out == 8'hC0)
		else $error("reserved index accepted");
	a_drive_rsvd_err: assert property (
		is_set && cmd_len_in == 8'h03 && cmd_d0_in <= 8'h04
		&& cmd_d2_in[2:0] == 3'h6 |=> reply_type_out == 8'hC0)
		else $error("drive 110 accepted");
	a_bad_value_err: assert property (
		is_set && cmd_d1_in > 8'h64 && cmd_d1_in < 8'hFF
		|=> reply_type_out == 8'hC0)
		else $error("invalid value accepted");
	a_state_upper_zero: assert property (
		reply_valid_out && reply_type_out == 8'h63
		|-> reply_d1_out[7:3] == 5'h00 && reply_d3_out[7:4] == 4'h0)
		else $error("reserved reply bits set");
	a_led_reads_zero: assert property (
		read_ok and (cmd_d0_in >= 8'h05)
		|=> reply_d1_out == 8'h00 && reply_d3_out == 8'h00)
		else $error("led state not zero");
endmodule
bind packet_gpio_pwm_port gpio_port_chk u_chk (.*);

// ===== tb/packet_gpio_pwm_port_tb.sv
/* self-checking bench for the packet gpio/pwm port.
   assumes short pwm and sample counts set at the instance. */
`timescale 1ns/1ps
module packet_gpio_pwm_port_tb;
	reg core_clk_in = 0, rst_n_in, cmd_valid_in;
	reg [7:0] cmd_type_in, cmd_len_in, cmd_d0_in, cmd_d1_in, cmd_d2_in;
	reg host_power_ctl_in, host_reset_ctl_in;
	reg [4:0] ext_en, ext_val;
	wire reply_valid_out, host_power_sense_out;
	wire [7:0] reply_type_out, reply_len_out, reply_d0_out, reply_d1_out;
	wire [7:0] reply_d2_out, reply_d3_out, led_output_channel_out;
	wire [4:0] pin_lvl, pin_out, pin_oe_n_out, pu, pd, user_ctl_out;
	integer n_errors = 0, n_checks = 0, i;
	reg [15:0] hi;
	always #4 core_clk_in = ~core_clk_in;
	packet_gpio_pwm_port #(.PWM_TICK_CYC(4), .SAMPLE_CYC(64))
		u_packet_gpio_pwm_port (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.cmd_valid_in(cmd_valid_in), .cmd_type_in(cmd_type_in),
		.cmd_len_in(cmd_len_in), .cmd_d0_in(cmd_d0_in),
		.cmd_d1_in(cmd_d1_in), .cmd_d2_in(cmd_d2_in),
		.reply_valid_out(reply_valid_out), .reply_type_out(reply_type_out),
		.reply_len_out(reply_len_out), .reply_d0_out(reply_d0_out),
		.reply_d1_out(reply_d1_out), .reply_d2_out(reply_d2_out),
		.reply_d3_out(reply_d3_out), .pin_in(pin_lvl), .pin_out(pin_out),
		.pin_oe_n_out(pin_oe_n_out), .pin_pullup_out(pu),
		.pin_pulldown_out(pd), .led_output_channel_out(led_output_channel_out),
		.host_power_sense_out(host_power_sense_out),
		.host_power_ctl_in(host_power_ctl_in),
		.host_reset_ctl_in(host_reset_ctl_in), .user_ctl_out(user_ctl_out));
	pin_pad_model u_pin_pad_model (.core_clk_in(core_clk_in),
		.pin_out_in(pin_out), .oe_n_in(pin_oe_n_out), .pullup_in(pu),
		.pulldown_in(pd), .ext_en_in(ext_en), .ext_val_in(ext_val),
		.pad_out(pin_lvl));
	task chk(input [15:0] got, input [15:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("ERROR %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// a gap cycle before each strobe keeps one assignment per step
	task send(input [7:0] t, l, a, b, c, et);
		begin
			@(posedge core_clk_in);
			#1 {cmd_valid_in, cmd_type_in, cmd_len_in, cmd_d0_in, cmd_d1_in,
				cmd_d2_in} = {1'b1, t, l, a, b, c};
			@(posedge core_clk_in);
			#1 cmd_valid_in = 0;
			chk(reply_valid_out, 1);
			chk(reply_type_out, et);
		end
	endtask
	task complete_run;
		begin
			$display("checks %0d errors %0d", n_checks, n_errors);
			if (n_errors == 0 && n_checks > 0) begin
				$display("Simulation passed");
			end else begin
				$display("Simulation failed");
			end
			$finish;
		end
	endtask
	initial begin
		#40000 n_errors = n_errors + 1;
		complete_run;
	end
	initial begin
		{cmd_valid_in, cmd_type_in, cmd_len_in, cmd_d0_in} = 0;
		{cmd_d1_in, cmd_d2_in, ext_en, ext_val} = 0;
		{host_power_ctl_in, host_reset_ctl_in, rst_n_in} = 0;
		repeat (6) @(posedge core_clk_in);
		chk(pin_oe_n_out, 16'h001F);
		#1 rst_n_in = 1;
		send(8'h22, 3, 0, 8'h64, 8'h09, 8'h62);
		repeat (140) @(posedge core_clk_in);
		send(8'h23, 1, 0, 0, 0, 8'h63);
		chk(reply_d1_out[0], 1);
		chk(reply_d2_out, 8'h64);
		chk(reply_d3_out, 8'h09);
		chk(user_ctl_out, 16'h0001);
		host_power_ctl_in = 1;
		repeat (2) @(posedge core_clk_in);
		#1 chk(pin_out[2], 1);
		send(8'h22, 2, 0, 8'h32, 8'h00, 8'h62);
		@(posedge core_clk_in);
		hi = 0;
		repeat (400) @(negedge core_clk_in) hi = hi + pin_lvl[0];
		chk(hi, 200);
		send(8'h22, 3, 0, 8'h64, 8'h06, 8'hC0);
		send(8'h22, 2, 8'h0D, 0, 0, 8'hC0);
		send(8'h23, 1, 8'hFF, 0, 0, 8'hC0);
		send(8'h22, 2, 0, 8'h65, 0, 8'hC0);
		send(8'h23, 1, 0, 0, 0, 8'h63);
		chk({reply_d2_out, reply_d3_out}, 16'h3209);
		send(8'h22, 3, 5, 8'h64, 8'h09, 8'h62);
		@(posedge core_clk_in);
		#1 chk(led_output_channel_out, 8'h01);
		send(8'h23, 1, 5, 0, 0, 8'h63);
		chk(reply_d1_out, 8'h00);
		chk({reply_d2_out, reply_d3_out}, 16'h6400);
		for (i = 0; i < 8; i = i + 1) begin
			send(8'h22, 3, 4, 0, 8'h08 | i, i == 6 ? 8'hC0 : 8'h62);
		end
		send(8'h22, 3, 4, 0, 8'h0A, 8'h62);
		ext_en = 5'h12;
		repeat (140) @(posedge core_clk_in);
		send(8'h23, 1, 4, 0, 0, 8'h63);
		ext_val = 5'h12;
		repeat (140) @(posedge core_clk_in);
		send(8'h23, 1, 4, 0, 0, 8'h63);
		chk(reply_d1_out, 8'h05);
		chk(reply_d0_out, 8'h04);
		chk(host_power_sense_out, 1);
		send(8'h23, 1, 4, 0, 0, 8'h63);
		chk(reply_d1_out, 8'h01);
		complete_run;
	end
endmodule

// ===== tb/pin_pad_model.sv
/* pad model for the five two-way pins.
   assumes oe low drives; bench may force a pad from outside. */
`timescale 1ns/1ps
module pin_pad_model (
	// clock
	input wire core_clk_in,
	// port side
	input wire [4:0] pin_out_in,
	input wire [4:0] oe_n_in,
	input wire [4:0] pullup_in,
	input wire [4:0] pulldown_in,
	// outside source
	input wire [4:0] ext_en_in,
	input wire [4:0] ext_val_in,
	output wire [4:0] pad_out
);
	reg [4:0] float_q = 5'h00;
	wire [4:0] own_d;
	// undriven pad wanders so a stale level never passes
	always @(posedge core_clk_in) begin
		float_q <= ~float_q;
	end
	assign own_d = (~oe_n_in & pin_out_in)
		| (oe_n_in & (pullup_in | (~pulldown_in & float_q)));
	assign pad_out = (ext_en_in & ext_val_in) | (~ext_en_in & own_d);
endmodule
